// [common/spr_cfg.svh]
// Purpose: Constants for the switch port pause enable resolver
// Assumes: Included by the package, by spr_top and by spr_checker
// Notes:   Register offsets are byte addresses on the register bus
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH

// Number of switch ports served
`define SPR_NUM_PORTS      3

// Register byte offsets, one aligned word per port
`define SPR_OFS_PORT0      32'h0000_0000
`define SPR_OFS_PORT1      32'h0000_0004
`define SPR_OFS_PORT2      32'h0000_0008
`define SPR_WORD_MASK      32'hFFFF_FFFC

// Field layout of a manual pause register
`define SPR_MANUAL_LSB     0
`define SPR_MANUAL_W       4
`define SPR_STATUS_LSB     4
`define SPR_STATUS_W       3
`define SPR_PAD_W          25

// Reset value of the writable manual fields
`define SPR_MANUAL_RST     4'h0

// Bus response codes
`define SPR_RESP_OKAY      2'h0
`define SPR_RESP_SLVERR    2'h2

// Byte lane that carries the writable fields
`define SPR_STRB_LANE      0

`endif

// [common/spr_pkg.sv]
// Purpose: Types shared by the pause enable resolver modules
// Assumes: Constants come from spr_cfg.svh
// Notes:   Packed field order matches the register layout
`include "spr_cfg.svh"

package spr_pkg;

	// Duplex and negotiation results from one attached PHY
	typedef struct packed {
		logic full_duplex;
		logic an_enable;
		logic an_complete;
		logic lp_an_able;
		logic adv_pause;
		logic adv_asym;
		logic lp_pause;
		logic lp_asym;
	} spr_phy_status_t;

	// Writable manual fields, rx at bit 0
	typedef struct packed {
		logic manual_pause_select;
		logic backpressure_enable;
		logic manual_tx_pause_enable;
		logic manual_rx_pause_enable;
	} spr_manual_t;

	// Resolved state of one port, duplex at bit 0
	typedef struct packed {
		logic tx_pause_enable;
		logic rx_pause_enable;
		logic full_duplex;
	} spr_enable_t;

	// Result of a register address decode
	typedef struct packed {
		logic       hit;
		logic [1:0] port;
	} spr_decode_t;

	// Resolution path taken for a port
	typedef enum logic [1:0] {
		SPR_MODE_MANUAL,
		SPR_MODE_AN_WAIT,
		SPR_MODE_AN_HALF,
		SPR_MODE_AN_FULL
	} spr_mode_t;

endpackage

// [core/spr_resolve.sv]
// Purpose: Combinational pause enable resolution for one port
// Assumes: Pause bits already carry local and partner roles
// Notes:   Registered by the instantiating module
`timescale 1ns/1ns
`default_nettype none

module spr_resolve (
	// Inputs from the PHY and the manual register
	input  wire spr_pkg::spr_phy_status_t phy_in,
	input  wire spr_pkg::spr_manual_t     manual_in,
	// Resolved enables
	output var  spr_pkg::spr_enable_t     enable_out
);
	import spr_pkg::*;

	spr_mode_t mode;

	// Pick the path; manual and non-negotiated ports skip the result
	always_comb begin
		if (manual_in.manual_pause_select || !phy_in.an_enable) begin
			mode = SPR_MODE_MANUAL;                      // see RULE_06
		end else if (!phy_in.an_complete) begin
			mode = SPR_MODE_AN_WAIT;                     // see RULE_08
		end else if (!phy_in.lp_an_able || !phy_in.full_duplex) begin
			mode = SPR_MODE_AN_HALF;                     // see RULE_09
		end else begin
			mode = SPR_MODE_AN_FULL;                     // see RULE_07
		end
	end

	// Enables per path; half duplex never honours pause frames
	always_comb begin
		enable_out = '0;
		case (mode)
			SPR_MODE_MANUAL: begin
				enable_out.full_duplex = phy_in.full_duplex;
				if (phy_in.full_duplex) begin
					enable_out.rx_pause_enable = manual_in.manual_rx_pause_enable; // see RULE_06
					enable_out.tx_pause_enable = manual_in.manual_tx_pause_enable; // see RULE_06
				end else begin
					enable_out.tx_pause_enable = manual_in.backpressure_enable;    // see RULE_05
				end
			end
			SPR_MODE_AN_WAIT: begin
				// Result not yet known, so both stay off
				enable_out.full_duplex = phy_in.full_duplex; // see RULE_08
			end
			SPR_MODE_AN_HALF: begin
				// Parallel detect forces half; partner bits ignored
				enable_out.tx_pause_enable = manual_in.backpressure_enable; // see RULE_05, see RULE_09
			end
			SPR_MODE_AN_FULL: begin
				enable_out.full_duplex = 1'b1;
				// Symmetric, or asymmetric from partner
				enable_out.rx_pause_enable = phy_in.adv_pause &&
					(phy_in.lp_pause || (phy_in.adv_asym && phy_in.lp_asym)); // see RULE_11, see RULE_12, see RULE_13
				// Symmetric, or asymmetric towards partner
				enable_out.tx_pause_enable = phy_in.lp_pause &&
					(phy_in.adv_pause || (phy_in.adv_asym && phy_in.lp_asym)); // see RULE_10, see RULE_11, see RULE_13
			end
			default: begin
				enable_out = '0;
			end
		endcase
	end

endmodule

`default_nettype wire

// [core/spr_top.sv]
// Purpose: Pause enable resolver for three switch ports with register access
// Assumes: PHY status inputs are synchronous to mclk_in
// Notes:   AXI4-Lite slave, one outstanding write and one outstanding read
//
// What this block does
// RULE_01: Each of three ports gets separate transmit and receive pause enables.
// RULE_02: Transmit enable means back pressure in half duplex, pause frames in full.
// RULE_03: Receive enable lets received pause frames stop the port's transmissions.
// RULE_04: Port 0 uses the virtual PHY, ports 1 and 2 physical PHYs.
// RULE_05: Half duplex: transmit follows backpressure enable, receive forced off.
// RULE_06: Full duplex, no negotiation or manual select: enables from manual bits.
// RULE_07: Full duplex, negotiation on, manual select clear: enables from negotiation.
// RULE_08: Negotiation on but incomplete, manual clear: both enables off.
// RULE_09: Partner unable to negotiate: half duplex, transmit follows backpressure enable.
// RULE_10: Local asym only, partner both: receive off, transmit on.
// RULE_11: Both sides symmetric pause: receive and transmit both on.
// RULE_12: Local both, partner asym only: receive on, transmit off.
// RULE_13: Any other negotiated full duplex combination: both enables off.
// RULE_14: Local bits from advertisement, partner bits from partner ability.
// RULE_15: Manual register writes never alter PHY advertisement pause bits.
// RULE_16: Software reads back active duplex and enables in the manual register.
// RULE_17: Virtual PHY port swaps local and partner pause bits.
// RULE_18: Enables are re-evaluated every clock from current inputs.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`include "spr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module spr_top #(
	parameter int ADDR_W    = 8,
	parameter int NUM_PORTS = `SPR_NUM_PORTS
) (
	// Clock and reset
	input  wire  logic                  mclk_in,
	input  wire  logic                  sys_rst_in,
	// AXI4-Lite write address
	input  wire  logic [ADDR_W-1:0]     s_axi_awaddr_in,
	input  wire  logic                  s_axi_awvalid_in,
	output logic                        s_axi_awready_out,
	// AXI4-Lite write data
	input  wire  logic [31:0]           s_axi_wdata_in,
	input  wire  logic [3:0]            s_axi_wstrb_in,
	input  wire  logic                  s_axi_wvalid_in,
	output logic                        s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp_out,
	output logic                        s_axi_bvalid_out,
	input  wire  logic                  s_axi_bready_in,
	// AXI4-Lite read address
	input  wire  logic [ADDR_W-1:0]     s_axi_araddr_in,
	input  wire  logic                  s_axi_arvalid_in,
	output logic                        s_axi_arready_out,
	// AXI4-Lite read data
	output logic [31:0]                 s_axi_rdata_out,
	output logic [1:0]                  s_axi_rresp_out,
	output logic                        s_axi_rvalid_out,
	input  wire  logic                  s_axi_rready_in,
	// Attached PHY results
	input  wire  spr_pkg::spr_phy_status_t vphy_status_in,
	input  wire  spr_pkg::spr_phy_status_t phya_status_in,
	input  wire  spr_pkg::spr_phy_status_t phyb_status_in,
	// Per-port enables towards the switch MACs
	output logic [NUM_PORTS-1:0]        port_tx_pause_enable_out,
	output logic [NUM_PORTS-1:0]        port_rx_pause_enable_out,
	output logic [NUM_PORTS-1:0]        port_full_duplex_out
);
	import spr_pkg::*;

	// Elaboration checks: PHY wiring is fixed to three ports
	if (NUM_PORTS != `SPR_NUM_PORTS) begin : g_bad_ports
		$error("spr_top: NUM_PORTS must be three");
	end
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
		$error("spr_top: ADDR_W must lie between 4 and 32");
	end

	// Manual registers and resolved state
	spr_manual_t     manual      [NUM_PORTS];
	spr_phy_status_t port_phy    [NUM_PORTS];
	spr_enable_t     next_enable [NUM_PORTS];
	spr_enable_t     enable      [NUM_PORTS];

	// Write channel holding state
	logic [ADDR_W-1:0] aw_addr;
	logic              aw_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              w_held;
	logic              write_go;
	spr_decode_t       wr_dec;
	spr_decode_t       rd_dec;

	// Decode an address into a port index; unmapped words miss
	function automatic spr_decode_t decode_addr(input logic [ADDR_W-1:0] addr);
		logic [31:0] word;
		spr_decode_t d;
		word = 32'(addr) & `SPR_WORD_MASK;
		d    = '0;
		if (word == `SPR_OFS_PORT0) begin
			d.hit  = 1'b1;
			d.port = 2'h0;
		end else if (word == `SPR_OFS_PORT1) begin
			d.hit  = 1'b1;
			d.port = 2'h1;
		end else if (word == `SPR_OFS_PORT2) begin
			d.hit  = 1'b1;
			d.port = 2'h2;
		end
		return d;
	endfunction

	// Readback word: active state above the manual fields
	function automatic logic [31:0] pack_word(input spr_manual_t m, input spr_enable_t e);
		return {{`SPR_PAD_W{1'b0}}, e, m}; // see RULE_16
	endfunction

	// Swap local and partner roles for the virtual PHY
	function automatic spr_phy_status_t swap_roles(input spr_phy_status_t s);
		spr_phy_status_t r;
		r           = s;
		r.adv_pause = s.lp_pause;
		r.adv_asym  = s.lp_asym;
		r.lp_pause  = s.adv_pause;
		r.lp_asym   = s.adv_asym;
		return r;
	endfunction

	// PHY to port mapping; pause bits come from advertisement and partner ability
	always_comb begin
		port_phy[0] = swap_roles(vphy_status_in); // see RULE_04, see RULE_17, see RULE_14
		port_phy[1] = phya_status_in;             // see RULE_04, see RULE_14
		port_phy[2] = phyb_status_in;             // see RULE_04, see RULE_14
	end

	// One resolver per port
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		spr_resolve u_resolve (
			.phy_in     (port_phy[p]),
			.manual_in  (manual[p]),
			.enable_out (next_enable[p])
		);
	end

	// Resolved state captured every cycle, so changes show next edge
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (sys_rst_in) begin
				enable[i] <= '0;
			end else begin
				enable[i] <= next_enable[i]; // see RULE_18
			end
		end
	end

	// Drive the MAC enables straight from flops
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (sys_rst_in) begin
				port_tx_pause_enable_out[i] <= 1'b0;
				port_rx_pause_enable_out[i] <= 1'b0;
				port_full_duplex_out[i]     <= 1'b0;
			end else begin
				// Tx: back pressure when half, pause frames when full
				port_tx_pause_enable_out[i] <= next_enable[i].tx_pause_enable; // see RULE_01, see RULE_02
				// Rx: honour received pause frames
				port_rx_pause_enable_out[i] <= next_enable[i].rx_pause_enable; // see RULE_01, see RULE_03
				port_full_duplex_out[i]     <= next_enable[i].full_duplex;     // see RULE_02
			end
		end
	end

	// Write commits once address and data are both held
	assign write_go = aw_held && w_held && !s_axi_bvalid_out;
	assign wr_dec   = decode_addr(aw_addr);
	assign rd_dec   = decode_addr(s_axi_araddr_in);

	// Write address channel; ready drops while a write is pending
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_axi_awready_out <= 1'b0;
			aw_held           <= 1'b0;
			aw_addr           <= '0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			s_axi_awready_out <= 1'b0;
			aw_held           <= 1'b1;
			aw_addr           <= s_axi_awaddr_in;
		end else if (write_go) begin
			aw_held           <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid_out) begin
			s_axi_awready_out <= 1'b1;
		end
	end

	// Write data channel, taken independently of the address
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_axi_wready_out <= 1'b0;
			w_held           <= 1'b0;
			w_data           <= '0;
			w_strb           <= '0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			s_axi_wready_out <= 1'b0;
			w_held           <= 1'b1;
			w_data           <= s_axi_wdata_in;
			w_strb           <= s_axi_wstrb_in;
		end else if (write_go) begin
			w_held           <= 1'b0;
		end else if (!w_held && !s_axi_bvalid_out) begin
			s_axi_wready_out <= 1'b1;
		end
	end

	// Write response; unmapped addresses answer SLVERR and store nothing
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= `SPR_RESP_OKAY;
		end else if (write_go) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= wr_dec.hit ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Manual registers; status bits are read-only, PHY advertisement untouched
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (sys_rst_in) begin
				manual[i] <= `SPR_MANUAL_RST;
			end else if (write_go && wr_dec.hit && wr_dec.port == 2'(i) && w_strb[`SPR_STRB_LANE]) begin
				manual[i] <= w_data[`SPR_MANUAL_LSB +: `SPR_MANUAL_W]; // see RULE_15
			end
		end
	end

	// Read address channel; one read outstanding at a time
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b0;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
		end else if (!s_axi_rvalid_out) begin
			s_axi_arready_out <= 1'b1;
		end
	end

	// Read data: state sampled at the address handshake
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= '0;
			s_axi_rresp_out  <= `SPR_RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'b1;
			if (rd_dec.hit) begin
				s_axi_rdata_out <= pack_word(manual[rd_dec.port], enable[rd_dec.port]); // see RULE_16
				s_axi_rresp_out <= `SPR_RESP_OKAY;
			end else begin
				s_axi_rdata_out <= '0;
				s_axi_rresp_out <= `SPR_RESP_SLVERR;
			end
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// [sim/spr_checker.sv]
// Purpose: Port-level assertions for the pause enable resolver
// Assumes: Bound to spr_top, watches ports 0 and 1 and the bus handshakes
// Notes:   Port 1 manual select is shadowed from bus writes, erring towards set
`include "spr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module spr_checker
	import spr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic            mclk_in,
	input wire logic            sys_rst_in,
	// Bus handshakes
	input wire logic            s_axi_awvalid_in,
	input wire logic            s_axi_awready_out,
	input wire logic            s_axi_wvalid_in,
	input wire logic            s_axi_wready_out,
	input wire logic            s_axi_bvalid_out,
	input wire logic            s_axi_bready_in,
	input wire logic            s_axi_arvalid_in,
	input wire logic            s_axi_arready_out,
	input wire logic            s_axi_rvalid_out,
	input wire logic            s_axi_rready_in,
	input wire logic [31:0]     s_axi_rdata_out,
	// Write payload, watched for the port 1 manual select
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic [31:0]     s_axi_wdata_in,
	input wire logic [3:0]      s_axi_wstrb_in,
	// PHY results and enables
	input wire spr_phy_status_t vphy_status_in,
	input wire spr_phy_status_t phya_status_in,
	input wire logic [2:0]      port_tx_pause_enable_out,
	input wire logic [2:0]      port_rx_pause_enable_out,
	input wire logic [2:0]      port_full_duplex_out
);
	import spr_pkg::*;

	// Parallel detect on port 1: negotiation done, partner cannot negotiate
	logic pd_a;
	assign pd_a = phya_status_in.an_enable & phya_status_in.an_complete & ~phya_status_in.lp_an_able;

	// Shadow of port 1 manual select: set at any data beat writing select through lane 0, cleared at the response to a port 1 lane 0 write clearing select
	logic [ADDR_W-1:0] aw_q;
	logic              w_sel_q;
	logic              w_lane_q;
	logic              sel_a;

	// Payload captured at each channel's handshake
	always_ff @(posedge mclk_in) begin
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_q <= s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_sel_q  <= s_axi_wdata_in[`SPR_MANUAL_LSB + `SPR_MANUAL_W - 1];
			w_lane_q <= s_axi_wstrb_in[`SPR_STRB_LANE];
		end
	end

	// Set early and cleared late, so the pd check never runs on a manual port
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sel_a <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out && s_axi_wstrb_in[`SPR_STRB_LANE]
				&& s_axi_wdata_in[`SPR_MANUAL_LSB + `SPR_MANUAL_W - 1]) begin
			sel_a <= 1'b1;
		end else if (s_axi_bvalid_out && s_axi_bready_in && w_lane_q && !w_sel_q
				&& (32'(aw_q) & `SPR_WORD_MASK) == `SPR_OFS_PORT1) begin
			sel_a <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	// Reset sampled in the antecedent so the release edge starts no attempt
	chk_half_rx_off: assert property (
		!sys_rst_in && !phya_status_in.full_duplex |=> !port_rx_pause_enable_out[1])
		else $error("receive enable set on half duplex port 1");
	chk_port0_vphy: assert property (
		!sys_rst_in && !vphy_status_in.full_duplex |=> !port_rx_pause_enable_out[0])
		else $error("port 0 receive enable ignores virtual PHY duplex");
	chk_pd_half: assert property (
		!sys_rst_in && pd_a && !sel_a |=> !port_full_duplex_out[1] && !port_rx_pause_enable_out[1])
		else $error("parallel detect did not force half duplex");
	chk_duplex_follows: assert property (
		!sys_rst_in && phya_status_in.full_duplex && !pd_a |=> port_full_duplex_out[1])
		else $error("port 1 duplex not taken from its PHY");
	chk_bresp_stands: assert property (
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped before handshake");
	chk_rdata_stands: assert property (
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data changed before handshake");
	chk_write_refused: assert property (
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write accepted while response pending");
	chk_read_answer: assert property (
		s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
		else $error("read answer late");
	chk_write_answer: assert property (
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
		else $error("write answer late");
endmodule

`default_nettype wire

// [sim/spr_phy_model.sv]
// Purpose: Behavioural model of the three PHYs feeding the resolver
// Assumes: Bench sets wanted link state, restart pulses renegotiate
// Notes:   Negotiation takes AN_CYCLES clocks so the waiting case shows
`timescale 1ns/1ns
`default_nettype none

module spr_phy_model
	import spr_pkg::*;
#(
	parameter int AN_CYCLES = 6
) (
	// Clock
	input  wire logic                     clk_in,
	// Wanted link state and restart per PHY
	input  wire spr_pkg::spr_phy_status_t want_in [3],
	input  wire logic [2:0]               restart_in,
	// Results shown to the resolver
	output var  spr_pkg::spr_phy_status_t status_out [3]
);
	import spr_pkg::*;

	int cnt [3] = '{0, 0, 0};

	// Completion held off while counting, advert and partner bits pass through
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 3; i++) begin
			cnt[i] <= (restart_in[i] || !want_in[i].an_enable) ? 0 : (cnt[i] < AN_CYCLES ? cnt[i] + 1 : cnt[i]);
			status_out[i] <= want_in[i];
			status_out[i].an_complete <= want_in[i].an_enable && !restart_in[i] && cnt[i] >= AN_CYCLES;
		end
	end
endmodule

`default_nettype wire

// [sim/switch_port_pause_enable_resolver_tb_top.sv]
// Purpose: Self-checking bench for the pause enable resolver
// Assumes: PHY model adds one clock of delay before the resolver
// Notes:   Port 1 carries the manual register scenarios
`timescale 1ns/1ns
`default_nettype none

module switch_port_pause_enable_resolver_tb_top;
	import spr_pkg::*;

	logic mclk_in = 1'b0, sys_rst_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
	logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'h0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [2:0] port_tx_pause_enable_out, port_rx_pause_enable_out, port_full_duplex_out, restart = 3'h0;
	spr_phy_status_t want [3] = '{8'h00, 8'h00, 8'h00};
	spr_phy_status_t st [3];
	int failures = 0, tests_run = 0;

	spr_top i_dut (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.vphy_status_in(st[0]), .phya_status_in(st[1]), .phyb_status_in(st[2]),
		.port_tx_pause_enable_out(port_tx_pause_enable_out),
		.port_rx_pause_enable_out(port_rx_pause_enable_out),
		.port_full_duplex_out(port_full_duplex_out)
	);
	spr_phy_model i_phy (.clk_in(mclk_in), .want_in(want), .restart_in(restart), .status_out(st));

	// 100 MHz clock
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end

	task automatic finish_test();
		$display("Checks run %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bits(input logic [2:0] got, input logic [2:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: enables %b expected %b", $time, got, exp);
		end
	endtask

	// Bounded wait for a handshake, sampled at the rising edge
	task automatic wait_hi(ref logic sig);
		int n;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (sig !== 1'b1 && n < 40);
		if (sig !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: handshake timed out", $time);
			finish_test();
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		bit aw_done, w_done;
		int n;
		aw_done = 1'b0;
		w_done = 1'b0;
		n = 0;
		@(posedge mclk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		// Each channel is released at the edge that takes it, in either order
		while (!(aw_done && w_done) && n < 40) begin
			@(posedge mclk_in);
			n++;
			if (!aw_done && s_axi_awready_out === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid_in <= 1'b0;
			end
			if (!w_done && s_axi_wready_out === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid_in <= 1'b0;
			end
		end
		if (!(aw_done && w_done)) begin
			failures++;
			$display("CHECK FAILED at %0t: write channels timed out", $time);
			finish_test();
		end
		wait_hi(s_axi_bvalid_out);
		cmp_word({30'h0, s_axi_bresp_out}, {30'h0, r});
		s_axi_bready_in <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge mclk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		wait_hi(s_axi_arready_out);
		s_axi_arvalid_in <= 1'b0;
		wait_hi(s_axi_rvalid_out);
		cmp_word(s_axi_rdata_out, d);
		cmp_word({30'h0, s_axi_rresp_out}, {30'h0, r});
		s_axi_rready_in <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// Same link state on all PHYs, virtual PHY gets the roles swapped
	task automatic set_phys(input logic [3:0] hd, input logic [3:0] b);
		@(posedge mclk_in);
		want[0] <= {hd, b[1:0], b[3:2]};
		want[1] <= {hd, b};
		want[2] <= {hd, b};
	endtask

	task automatic check_en(input logic [2:0] fd, input logic [2:0] rx, input logic [2:0] tx);
		cmp_bits(port_full_duplex_out, fd);
		cmp_bits(port_rx_pause_enable_out, rx);
		cmp_bits(port_tx_pause_enable_out, tx);
	endtask

	task automatic test_reset_regs();
		axi_wr(8'h08, 32'h0000000F, 4'hF, 2'h0);
		@(posedge mclk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		settle(1);
		check_en(3'h0, 3'h0, 3'h0);
		for (int i = 0; i < 3; i++) axi_rd(8'(4 * i), 32'h0, 2'h0);
		axi_rd(8'h0C, 32'h0, 2'h2);
		axi_wr(8'h0C, 32'h0000000F, 4'hF, 2'h2);
	endtask

	// Every advert and partner combination, expectations from the resolution table
	task automatic test_neg_table();
		logic ap, aa, lp, la, rx, tx;
		set_phys(4'hD, 4'h0);
		settle(10);
		// Manual bits on port 1 must not leak into the negotiated path
		axi_wr(8'h04, 32'h00000003, 4'hF, 2'h0);
		for (int b = 0; b < 16; b++) begin
			{ap, aa, lp, la} = 4'(b);
			rx = (ap & lp) | (ap & aa & ~lp & la);
			tx = (ap & lp) | (~ap & aa & lp & la);
			set_phys(4'hD, 4'(b));
			settle(2);
			check_en(3'h7, {3{rx}}, {3{tx}});
		end
		axi_rd(8'h04, 32'h00000073, 2'h0);
	endtask

	task automatic test_an_wait();
		@(posedge mclk_in);
		restart <= 3'h7;
		@(posedge mclk_in);
		restart <= 3'h0;
		settle(1);
		check_en(3'h7, 3'h0, 3'h0);
		settle(9);
		check_en(3'h7, 3'h7, 3'h7);
	endtask

	task automatic test_manual();
		axi_wr(8'h04, 32'h0000000A, 4'hF, 2'h0);
		axi_rd(8'h04, 32'h0000005A, 2'h0);
		check_en(3'h7, 3'h5, 3'h7);
		set_phys(4'h5, 4'hF);
		axi_wr(8'h04, 32'h0000000E, 4'hF, 2'h0);
		axi_rd(8'h04, 32'h0000004E, 2'h0);
		check_en(3'h0, 3'h0, 3'h2);
		set_phys(4'h8, 4'hF);
		axi_wr(8'h04, 32'h00000001, 4'hF, 2'h0);
		axi_rd(8'h04, 32'h00000031, 2'h0);
		check_en(3'h7, 3'h2, 3'h0);
		axi_wr(8'h04, 32'h0000000F, 4'h0, 2'h0);
		axi_rd(8'h04, 32'h00000031, 2'h0);
	endtask

	task automatic test_parallel_detect();
		set_phys(4'hC, 4'hF);
		settle(9);
		axi_wr(8'h04, 32'h00000004, 4'hF, 2'h0);
		axi_rd(8'h04, 32'h00000044, 2'h0);
		check_en(3'h0, 3'h0, 3'h2);
	endtask

	// Main sequence after an 8 clock reset
	initial begin
		repeat (8) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		test_reset_regs();
		test_neg_table();
		test_an_wait();
		test_manual();
		test_parallel_detect();
		finish_test();
	end
endmodule

bind spr_top spr_checker #(.ADDR_W(ADDR_W)) i_chk (
	.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_awaddr_in(s_axi_awaddr_in),
	.s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
	.vphy_status_in(vphy_status_in), .phya_status_in(phya_status_in),
	.port_tx_pause_enable_out(port_tx_pause_enable_out),
	.port_rx_pause_enable_out(port_rx_pause_enable_out),
	.port_full_duplex_out(port_full_duplex_out)
);

`default_nettype wire
